// ==== tdm_stream_timing.sv ====
// Purpose: Serial stream timing and configuration of a 16x16 TDM switch
// Assumes: Pins sampled at 250 MHz; switching core supplies outgoing bits
// Notes:   Registers reached over a plain strobe port, read data next cycle
//
// What this block does
// - Decode 14-bit host address to registers
// - Reset: drivers off, defaults, counters cleared
// - Bidirectional bit forces serial inputs low
// - 32 to 256 channels per frame
// - Input rate from input control bits 3-0
// - Output rate from output control bits 3-0
// - At most 1024 channels switched
// - Only whole streams can be enabled
// - Clock select field gives clock and pulse
// - Clock polarity bit selects rising edge
// - Position and polarity bits select alternate timing
// - Frame pulse and clock time input sampling
// - Outputs timed from same pulse and clock
// - Message mode sends host data instead
// - Drive enable pin gates all output drivers
module tdm_stream_timing
    import tdm_pkg::*;
#(
    parameter int FRAME_LIMIT = tdm_pkg::FRAME_CYCLES
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    // Register port
    input wire logic [tdm_pkg::ADDR_W-1:0] host_address_bus,
    input wire logic [tdm_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [tdm_pkg::DATA_W-1:0] rd_data,
    // Pins
    input wire logic bus_style_select,
    input wire logic output_drive_enable,
    input wire logic serial_clock_in,
    input wire logic frame_pulse_in,
    input wire logic [tdm_pkg::STREAMS-1:0] serial_inputs,
    input wire logic [tdm_pkg::STREAMS-1:0] serial_outputs_in,
    output logic [tdm_pkg::STREAMS-1:0] serial_outputs_out,
    output logic [tdm_pkg::STREAMS-1:0] serial_outputs_oe,
    // Switching core side
    input wire logic [tdm_pkg::STREAMS-1:0] switched_bits,
    output logic [tdm_pkg::STREAMS-1:0][7:0] rx_byte,
    output logic [tdm_pkg::STREAMS-1:0][7:0] rx_channel,
    output logic [tdm_pkg::STREAMS-1:0] rx_valid,
    output logic frame_start
);
    import tdm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Returns {valid, shift}: clock edges per bit is 2**shift
    // Clock runs at two, four or eight times the rate, at the rate itself only for the top rate
    function automatic logic [3:0] rate_shift(input logic [1:0] csel, input logic [3:0] rate);
        logic [3:0] sum;
        sum = {2'b00, csel} + 4'h2;
        if (rate >= RATE_2M && rate <= RATE_16M && csel <= CKIN_16M &&
            (sum > rate || (sum == rate && rate == RATE_16M)))
            return {1'b1, 3'(sum - rate)};
        return 4'h0;
    endfunction

    function automatic logic [12:0] rate_channels(input logic [3:0] rate);
        case (rate)
            RATE_2M: return 13'h0020;
            RATE_4M: return 13'h0040;
            RATE_8M: return 13'h0080;
            RATE_16M: return 13'h0100;
            default: return 13'h0000;
        endcase
    endfunction

    function automatic logic [10:0] low_mask(input logic [2:0] sh);
        return 11'((12'h001 << sh) - 12'h001);
    endfunction

    function automatic logic in_block(input logic [13:0] addr, input logic [13:0] base);
        return addr[13:4] == base[13:4];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [35:0] pins_s;
    logic [STREAMS-1:0] serial_inputs_s;
    logic [STREAMS-1:0] serial_outputs_in_s;
    logic ck_s;
    logic fp_s;
    logic ode_s;
    logic style_s;

    pin_sync #(.W(36)) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .raw({bus_style_select, output_drive_enable, frame_pulse_in, serial_clock_in,
              serial_outputs_in, serial_inputs}),
        .stable(pins_s)
    );

    assign serial_inputs_s = pins_s[15:0];
    assign serial_outputs_in_s = pins_s[31:16];
    assign ck_s = pins_s[32];
    assign fp_s = pins_s[33];
    assign ode_s = pins_s[34];
    assign style_s = pins_s[35];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] main_control_reg;
    logic [15:0] internal_mode_reg;
    logic [15:0] stream_input_ctrl [0:STREAMS-1];
    logic [15:0] stream_output_ctrl [0:STREAMS-1];
    logic [8:0] msg_ctrl [0:STREAMS-1];
    logic [7:0] msg_data [0:STREAMS-1];
    logic [15:0] status;
    logic [15:0] next_rd_data;
    logic [3:0] idx;
    logic cap_error;
    sync_state_t sync_state;

    logic [1:0] clock_freq_select;
    logic clock_polarity_bit;
    logic frame_pulse_polarity_bit;
    logic frame_pulse_position_bit;
    logic bidir_mode_bit;
    logic gci_mode;

    assign clock_freq_select = main_control_reg[CR_CKIN_LSB +: 2];
    assign clock_polarity_bit = main_control_reg[CR_CLOCK_POLARITY_BIT_BIT];
    assign frame_pulse_polarity_bit = main_control_reg[CR_FRAME_PULSE_POLARITY_BIT_BIT];
    assign frame_pulse_position_bit = main_control_reg[CR_FPPOS_BIT];
    assign bidir_mode_bit = internal_mode_reg[IMS_BIDIR_BIT];
    assign gci_mode = frame_pulse_position_bit & frame_pulse_polarity_bit;
    assign idx = host_address_bus[3:0];

    // bus style reported from the pin
    assign status = {12'h000, sync_state == SYNC_LOCKED, gci_mode, cap_error, style_s};

    // address decode of the 14-bit port
    assign next_rd_data =
        (host_address_bus == CR_ADDR) ? main_control_reg :
        (host_address_bus == IMS_ADDR) ? internal_mode_reg :
        (host_address_bus == STATUS_ADDR) ? status :
        in_block(host_address_bus, SICR_BASE) ? stream_input_ctrl[idx] :
        in_block(host_address_bus, SOCR_BASE) ? stream_output_ctrl[idx] :
        in_block(host_address_bus, MSGC_BASE) ? {7'h00, msg_ctrl[idx]} :
        in_block(host_address_bus, MSGD_BASE) ? {8'h00, msg_data[idx]} : 16'h0000;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            main_control_reg <= CR_RESET;
            internal_mode_reg <= IMS_RESET;
            rd_data <= 16'h0000;
            for (int n = 0; n < STREAMS; n++) begin
                stream_input_ctrl[n] <= STREAM_CTRL_RESET;
                stream_output_ctrl[n] <= STREAM_CTRL_RESET;
                msg_ctrl[n] <= 9'h000;
                msg_data[n] <= 8'h00;
            end
        end else if (ce) begin
            if (rd_stb) begin
                rd_data <= next_rd_data;
            end
            if (wr_stb) begin
                if (host_address_bus == CR_ADDR)
                    main_control_reg <= wr_data;
                if (host_address_bus == IMS_ADDR)
                    internal_mode_reg <= wr_data;
                if (in_block(host_address_bus, SICR_BASE))
                    stream_input_ctrl[idx] <= wr_data;
                if (in_block(host_address_bus, SOCR_BASE))
                    stream_output_ctrl[idx] <= wr_data;
                if (in_block(host_address_bus, MSGC_BASE))
                    msg_ctrl[idx] <= wr_data[8:0];
                if (in_block(host_address_bus, MSGD_BASE))
                    msg_data[idx] <= wr_data[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-stream configuration
    logic [3:0] in_cfg [0:STREAMS-1];
    logic [3:0] out_cfg [0:STREAMS-1];
    logic [12:0] in_total;
    logic [12:0] out_total;

    // a stream is enabled whole from its rate field
    for (genvar g = 0; g < STREAMS; g++) begin : g_cfg
        assign in_cfg[g] = rate_shift(clock_freq_select, stream_input_ctrl[g][3:0]);
        assign out_cfg[g] = rate_shift(clock_freq_select, stream_output_ctrl[g][3:0]);
    end

    always_comb begin
        in_total = 13'h0000;
        out_total = 13'h0000;
        for (int n = 0; n < STREAMS; n++) begin
            if (in_cfg[n][3])
                in_total = in_total + rate_channels(stream_input_ctrl[n][3:0]);
            if (out_cfg[n][3])
                out_total = out_total + rate_channels(stream_output_ctrl[n][3:0]);
        end
    end

    assign cap_error = (in_total > MAX_CHANNELS) || (out_total > MAX_CHANNELS);

    ////////////////////////////////////////////////////////////////////////////
    // Frame timing
    logic ck_prev;
    logic act_edge;
    logic fp_act;
    logic fp_taken;
    logic boundary;
    logic edge_d;
    logic [10:0] ck_count;
    logic [16:0] watchdog;

    // default falling edge, rising when polarity bit set
    assign act_edge = clock_polarity_bit ? (ck_s & ~ck_prev) : (~ck_s & ck_prev);
    assign fp_act = frame_pulse_polarity_bit ? fp_s : ~fp_s;
    // boundary at first active edge inside the pulse
    assign boundary = act_edge & fp_act & ~fp_taken;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ck_prev <= 1'b0;
            fp_taken <= 1'b0;
            edge_d <= 1'b0;
            ck_count <= 11'h000;
            frame_start <= 1'b0;
            watchdog <= 17'h00000;
            sync_state <= SYNC_HUNT;
        end else if (ce) begin
            ck_prev <= ck_s;
            edge_d <= act_edge;
            frame_start <= boundary;
            if (act_edge)
                fp_taken <= fp_act;
            if (boundary)
                ck_count <= 11'h000;
            else if (act_edge)
                ck_count <= ck_count + 11'h001;
            if (boundary) begin
                watchdog <= 17'h00000;
                sync_state <= SYNC_LOCKED;
            end else begin
                case (sync_state)
                    SYNC_HUNT: watchdog <= 17'h00000;
                    SYNC_LOCKED: begin
                        watchdog <= watchdog + 17'h00001;
                        if (watchdog >= 17'(2 * FRAME_LIMIT))
                            sync_state <= SYNC_HUNT;
                    end
                    default: sync_state <= SYNC_HUNT;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stream bit engines
    logic [STREAMS-1:0] rx_src;
    logic [STREAMS-1:0] forced_inputs;
    logic [STREAMS-1:0] in_sample;
    logic [STREAMS-1:0] out_tick;
    logic [STREAMS-1:0] tx_bit;
    logic [STREAMS-1:0] msg_hit;
    logic [7:0] rx_shift [0:STREAMS-1];
    logic [7:0] next_shift [0:STREAMS-1];
    logic [10:0] in_bitno [0:STREAMS-1];
    logic [10:0] out_bitno [0:STREAMS-1];

    // serial inputs tied low in bidirectional mode
    assign forced_inputs = serial_inputs_s & ~{STREAMS{bidir_mode_bit}};
    assign rx_src = bidir_mode_bit ? serial_outputs_in_s : forced_inputs;

    for (genvar g = 0; g < STREAMS; g++) begin : g_bit
        assign in_bitno[g] = ck_count >> in_cfg[g][2:0];
        assign out_bitno[g] = ck_count >> out_cfg[g][2:0];
        // sample on the last edge of each bit
        assign in_sample[g] = edge_d & in_cfg[g][3] &
            ((ck_count & low_mask(in_cfg[g][2:0])) == low_mask(in_cfg[g][2:0]));
        // launch on the first edge of each bit
        assign out_tick[g] = edge_d & out_cfg[g][3] &
            ((ck_count & low_mask(out_cfg[g][2:0])) == 11'h000);
        assign next_shift[g] = gci_mode ? {rx_src[g], rx_shift[g][7:1]}
                                        : {rx_shift[g][6:0], rx_src[g]};
        // message data replaces switched data on the chosen channel
        assign msg_hit[g] = msg_ctrl[g][MSG_EN_BIT] & (msg_ctrl[g][7:0] == out_bitno[g][10:3]);
        assign tx_bit[g] = ~msg_hit[g] ? switched_bits[g] :
            gci_mode ? msg_data[g][out_bitno[g][2:0]] : msg_data[g][3'h7 - out_bitno[g][2:0]];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_valid <= '0;
            rx_byte <= '0;
            rx_channel <= '0;
            serial_outputs_out <= '0;
            serial_outputs_oe <= '0;
            for (int n = 0; n < STREAMS; n++)
                rx_shift[n] <= 8'h00;
        end else if (ce) begin
            for (int n = 0; n < STREAMS; n++) begin
                rx_valid[n] <= 1'b0;
                if (in_sample[n]) begin
                    rx_shift[n] <= next_shift[n];
                    if (in_bitno[n][2:0] == 3'h7) begin
                        rx_byte[n] <= next_shift[n];
                        rx_channel[n] <= in_bitno[n][10:3];
                        rx_valid[n] <= 1'b1;
                    end
                end
                if (out_tick[n])
                    serial_outputs_out[n] <= tx_bit[n];
                // drive only when enabled and within capacity
                serial_outputs_oe[n] <= ode_s & out_cfg[n][3] & ~cap_error;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_cr_read;
        ce && rd_stb && host_address_bus == CR_ADDR;
    endsequence

    sequence s_boundary;
        ce && boundary;
    endsequence

    a_cr_read_data: assert property (
        @(posedge mclk) disable iff (!reset_n) s_cr_read |=> rd_data == $past(main_control_reg))
        else $error("control register read data wrong");

    a_reset_drivers_off: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> serial_outputs_oe == '0 && ck_count == 11'h000)
        else $error("drivers or counter active after reset");

    a_bidir_ignore: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ce && bidir_mode_bit && !gci_mode && in_sample[0]
        |=> rx_shift[0][0] == $past(serial_outputs_in_s[0]))
        else $error("serial inputs not ignored in bidirectional mode");

    a_capacity_off: assert property (
        @(posedge mclk) disable iff (!reset_n) ce && cap_error |=> serial_outputs_oe == '0)
        else $error("drivers on while over capacity");

    a_drive_enable: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ce && ode_s && out_cfg[0][3] && !cap_error |=> serial_outputs_oe[0])
        else $error("stream 0 not driven while enabled");

    a_frame_restart: assert property (
        @(posedge mclk) disable iff (!reset_n) s_boundary |=> ck_count == 11'h000 && frame_start)
        else $error("counter not restarted at frame boundary");

    a_rate_slots: assert property (
        @(posedge mclk) disable iff (!reset_n)
        in_sample[0] |-> in_cfg[0][3] && stream_input_ctrl[0][3:0] != RATE_OFF)
        else $error("sampling on a disabled input stream");

    a_message_bit: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ce && out_tick[0] && msg_hit[0] && !gci_mode
        |=> serial_outputs_out[0] == $past(msg_data[0][3'h7 - out_bitno[0][2:0]]))
        else $error("message bit not sent");

    a_gci_needs_both: assert property (
        @(posedge mclk) disable iff (!reset_n)
        gci_mode |-> main_control_reg[CR_FPPOS_BIT] && main_control_reg[CR_FRAME_PULSE_POLARITY_BIT_BIT])
        else $error("alternate timing without both bits");

    a_edge_polarity: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ce && act_edge |-> (clock_polarity_bit ? ck_s : !ck_s) ##1 !act_edge)
        else $error("active edge of wrong polarity");

endmodule // tdm_stream_timing

// ==== tdm_pkg.sv ====
// Purpose: Shared constants for the TDM stream timing front end
// Assumes: 250 MHz mclk, 14-bit word-addressed register port, 16-bit data
// Notes:   All offsets are word indices on the plain register port
package tdm_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int STREAMS = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [13:0] CR_ADDR = 14'h0000;
    localparam logic [13:0] IMS_ADDR = 14'h0001;
    localparam logic [13:0] STATUS_ADDR = 14'h0002;
    localparam logic [13:0] SICR_BASE = 14'h0100;
    localparam logic [13:0] SOCR_BASE = 14'h0200;
    localparam logic [13:0] MSGC_BASE = 14'h0300;
    localparam logic [13:0] MSGD_BASE = 14'h0310;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CR_CKIN_LSB = 5;
    localparam int CR_FRAME_PULSE_POLARITY_BIT_BIT = 7;
    localparam int CR_CLOCK_POLARITY_BIT_BIT = 8;
    localparam int CR_FPPOS_BIT = 9;
    localparam int IMS_BIDIR_BIT = 6;
    localparam int MSG_EN_BIT = 8;
    localparam int ST_STYLE_BIT = 0;
    localparam int ST_CAP_BIT = 1;
    localparam int ST_GCI_BIT = 2;
    localparam int ST_LOCK_BIT = 3;

    // Reset values
    localparam logic [15:0] CR_RESET = 16'h0000;
    localparam logic [15:0] IMS_RESET = 16'h0000;
    localparam logic [15:0] STREAM_CTRL_RESET = 16'h0000;

    // Rate field codes
    localparam logic [3:0] RATE_OFF = 4'h0;
    localparam logic [3:0] RATE_2M = 4'h1;
    localparam logic [3:0] RATE_4M = 4'h2;
    localparam logic [3:0] RATE_8M = 4'h3;
    localparam logic [3:0] RATE_16M = 4'h4;

    // Supplied clock frequency codes
    localparam logic [1:0] CKIN_4M = 2'h0;
    localparam logic [1:0] CKIN_8M = 2'h1;
    localparam logic [1:0] CKIN_16M = 2'h2;

    localparam logic [12:0] MAX_CHANNELS = 13'h0400;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 250;
    localparam int FRAME_US = 125;
    localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;

    typedef enum logic {SYNC_HUNT, SYNC_LOCKED} sync_state_t;

endpackage

// ==== pin_sync.sv ====
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to mclk
// Notes:   Output moves only when stages two and three agree
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    // Pins
    input wire logic [W-1:0] raw,
    output logic [W-1:0] stable
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] agree;

    assign agree = ~(s2 ^ s3);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            stable <= '0;
        end else if (ce) begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            stable <= (stable & ~agree) | (s3 & agree);
        end
    end

endmodule // pin_sync

// ==== tdm_peer_model.sv ====
// Purpose: Peer TDM device driving clock, frame pulse and input streams
// Assumes: Negative clock, active low pulse, clock equal to the data rate
// Notes:   Clock stands high between bursts of frames
module tdm_peer_model (
    // Pins toward the switch
    output logic serial_clock_in,
    output logic frame_pulse_in,
    output logic [15:0] serial_inputs
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HP = 40;
    logic [7:0] cur;

    initial begin
        serial_clock_in = 1'b1;
        frame_pulse_in = 1'b1;
        serial_inputs = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one bit per clock
    // Bit b stands at the b-th falling edge after the boundary edge
    task automatic run_frames(input int frames, input int chans);
        for (int f = 0; f < frames; f++) begin
            for (int b = 0; b < chans * 8; b++) begin
                frame_pulse_in = (b != 0);
                for (int s = 0; s < 16; s++) begin
                    cur = 8'(b / 8 * 16 + s) ^ 8'h5A;
                    serial_inputs[s] = cur[7 - b % 8];
                end
                #HP serial_clock_in = 1'b0;
                #HP serial_clock_in = 1'b1;
            end
        end
        // Lines are left at the inverse of the last bits driven
        serial_inputs = ~serial_inputs;
    endtask
endmodule // tdm_peer_model

// ==== tb_tdm_stream_timing.sv ====
// Purpose: Self-checking bench for the TDM stream timing block
// Assumes: Peer model supplies clock, pulse and input streams
// Notes:   Short frames of four channels keep the run brief
module tb_tdm_stream_timing;
    import tdm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n, ce, wr_stb, rd_stb, bus_style_select, output_drive_enable, bidir;
    logic serial_clock_in, frame_pulse_in, frame_start;
    logic [13:0] host_address_bus;
    logic [15:0] wr_data, rd_data, rd_val, serial_outputs_in, serial_outputs_out;
    logic [15:0] serial_outputs_oe, switched_bits, serial_inputs, rx_valid;
    logic [15:0][7:0] rx_byte, rx_channel;
    logic [13:0] regs [4] = '{CR_ADDR, IMS_ADDR, SICR_BASE + 14'h0005, SOCR_BASE + 14'h000F};
    int fails = 0, n_tests = 0, n_rx = 0, n_fs = 0, seed = 32'h3B9AFC0B;
    localparam logic [7:0] MSG = 8'hA7;

    always #2 mclk = ~mclk;
    // Two-way pins have pull-downs, so undriven pins read low
    assign serial_outputs_in = serial_outputs_oe & serial_outputs_out;

    tdm_stream_timing #(.FRAME_LIMIT(2000)) u_tdm_stream_timing (
        .mclk(mclk), .reset_n(reset_n), .ce(ce), .host_address_bus(host_address_bus),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .bus_style_select(bus_style_select), .output_drive_enable(output_drive_enable),
        .serial_clock_in(serial_clock_in), .frame_pulse_in(frame_pulse_in),
        .serial_inputs(serial_inputs), .serial_outputs_in(serial_outputs_in),
        .serial_outputs_out(serial_outputs_out), .serial_outputs_oe(serial_outputs_oe),
        .switched_bits(switched_bits), .rx_byte(rx_byte), .rx_channel(rx_channel),
        .rx_valid(rx_valid), .frame_start(frame_start));
    tdm_peer_model u_tdm_peer_model (.serial_clock_in(serial_clock_in),
        .frame_pulse_in(frame_pulse_in), .serial_inputs(serial_inputs));

    // Loop-back in bidirectional mode trails the launched stream by one bit
    function automatic logic [7:0] exp_byte(input int s, input logic [7:0] ch);
        if (!bidir)
            return ((ch * 8'h10) + 8'(s)) ^ 8'h5A;
        if (s != 0)
            return 8'h00;
        return (ch == 8'h02) ? (MSG >> 1) : (ch == 8'h03) ? {MSG[0], 7'h00} : 8'h00;
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic reg_wr(input logic [13:0] a, input logic [15:0] d);
        host_address_bus <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic reg_rd(input logic [13:0] a);
        host_address_bus <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 rd_val = rd_data;
        @(posedge mclk);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        switched_bits <= bidir ? 16'h0000 : 16'($random(seed));
        if (frame_start === 1'b1) begin
            n_fs++;
        end
        for (int s = 0; s < 4; s++) begin
            if (rx_valid[s] === 1'b1) begin
                n_rx++;
                check("rx_byte", 16'(rx_byte[s]), 16'(exp_byte(s, rx_channel[s])));
            end
        end
    end

    initial begin
        logic [15:0] d;
        reset_n = 1'b0;
        ce = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        host_address_bus = 14'h0000;
        wr_data = 16'h0000;
        bus_style_select = 1'b1;
        output_drive_enable = 1'b1;
        switched_bits = 16'h00FF;
        bidir = 1'b0;
        repeat (12) @(posedge mclk);
        check("oe_in_reset", serial_outputs_oe, 16'h0000);
        reset_n <= 1'b1;
        settle(8);
        foreach (regs[i]) begin
            reg_rd(regs[i]);
            check("reset_value", rd_val, 16'h0000);
        end
        repeat (4) foreach (regs[i]) begin
            d = 16'($random(seed));
            reg_wr(regs[i], d);
            reg_wr(14'h2000 | regs[i], ~d);
            reg_rd(regs[i]);
            check("readback", rd_val, d);
            reg_rd(14'h2000 | regs[i]);
            check("unmapped", rd_val, 16'h0000);
        end
        foreach (regs[i]) reg_wr(regs[i], 16'h0000);
        $display("test registers done");
        for (int v = 0; v < 2; v++) begin
            bus_style_select <= v[0];
            settle(8);
            reg_rd(STATUS_ADDR);
            check("style", 16'(rd_val[ST_STYLE_BIT]), 16'(v[0]));
        end
        $display("test style done");
        reg_wr(CR_ADDR, 16'h0040);
        for (int s = 0; s < 8; s++) reg_wr(SOCR_BASE + 14'(s), 16'(RATE_8M));
        settle(8);
        check("oe_full", serial_outputs_oe, 16'h00FF);
        reg_rd(STATUS_ADDR);
        check("cap_ok", 16'(rd_val[ST_CAP_BIT]), 16'h0000);
        output_drive_enable <= 1'b0;
        settle(8);
        check("oe_drive_off", serial_outputs_oe, 16'h0000);
        output_drive_enable <= 1'b1;
        reg_wr(SOCR_BASE + 14'h0008, 16'(RATE_2M));
        settle(8);
        check("oe_over", serial_outputs_oe, 16'h0000);
        reg_rd(STATUS_ADDR);
        check("cap_err", 16'(rd_val[ST_CAP_BIT]), 16'h0001);
        for (int s = 0; s < 9; s++) reg_wr(SOCR_BASE + 14'(s), 16'h0000);
        $display("test capacity done");
        for (int i = 0; i < 4; i++) begin
            reg_wr(CR_ADDR, 16'h0040 | (16'(i[0]) << CR_FRAME_PULSE_POLARITY_BIT_BIT) | (16'(i[1]) << CR_FPPOS_BIT));
            reg_rd(STATUS_ADDR);
            check("alt_timing", 16'(rd_val[ST_GCI_BIT]), 16'(i == 3));
        end
        reg_wr(CR_ADDR, 16'h0040);
        $display("test timing select done");
        for (int s = 0; s < 4; s++) reg_wr(SICR_BASE + 14'(s), 16'(RATE_16M));
        u_tdm_peer_model.run_frames(3, 4);
        settle(20);
        check("frames", 16'(n_fs), 16'h0003);
        check("rx_count", 16'(n_rx), 16'h0030);
        reg_rd(STATUS_ADDR);
        check("lock", 16'(rd_val[ST_LOCK_BIT]), 16'h0001);
        $display("test receive done");
        bidir = 1'b1;
        reg_wr(IMS_ADDR, 16'h0040);
        reg_wr(SOCR_BASE, 16'(RATE_16M));
        reg_wr(MSGD_BASE, 16'(MSG));
        reg_wr(MSGC_BASE, 16'h0102);
        settle(8);
        check("oe_bidir", serial_outputs_oe, 16'h0001);
        u_tdm_peer_model.run_frames(1, 4);
        settle(20);
        check("rx_bidir", 16'(n_rx), 16'h0040);
        $display("test bidir done");
        reset_n <= 1'b0;
        repeat (251) @(posedge mclk);
        check("oe_reset", serial_outputs_oe, 16'h0000);
        reset_n <= 1'b1;
        settle(8);
        reg_rd(MSGC_BASE);
        check("msg_reset", rd_val, 16'h0000);
        $display("test reset done");
        print_verdict();
    end

    initial begin
        #200000;
        fails++;
        print_verdict();
    end
endmodule // tb_tdm_stream_timing
